/* File: core/smsp_pkg.sv */
package smsp_pkg;
   // =====================================================
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_CONTROL = 8'h2c;
   localparam logic [7:0] IDX_STATUS = 8'h2d;
   localparam logic [7:0] IDX_DATA = 8'h2e;
   localparam logic [7:0] IDX_PINDIR = 8'h2f;
   // =====================================================
   // Field positions.
   localparam int CTL_IE = 7;
   localparam int CTL_EN = 6;
   localparam int CTL_LSB = 5;
   localparam int CTL_MST = 4;
   localparam int CTL_CPOL = 3;
   localparam int CTL_CPHA = 2;
   localparam int CTL_R1 = 1;
   localparam int CTL_R0 = 0;
   localparam int ST_DONE = 7;
   localparam int ST_COL = 6;
   localparam int ST_DSPEED = 0;
   localparam int DIR_MOSI = 0;
   localparam int DIR_MISO = 1;
   localparam int DIR_SCK = 2;
   localparam int DIR_SS = 3;
   localparam int DIR_SSVAL = 4;
   // =====================================================
   // Reset values and counts.
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [4:0] PINDIR_RST = 5'h00;
   localparam logic [1:0] DRAIN_LEN = 2'h3;
   localparam logic [3:0] LAST_EDGE = 4'hf;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // Half SCK period in core clocks, indexed by {double_speed, rate_sel}.
   localparam logic [6:0] HALF_TABLE [8] = '{7'h02, 7'h08, 7'h20, 7'h40,
                                             7'h01, 7'h04, 7'h10, 7'h20};
   // =====================================================
   typedef enum logic [1:0] {MST_IDLE, MST_RUN, MST_DRAIN} smsp_mst_t;
   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss;
   } smsp_pin_in_t;
   typedef struct packed {
      logic sckOut;
      logic sckOe;
      logic mosiOut;
      logic mosiOe;
      logic misoOut;
      logic misoOe;
      logic ssOut;
      logic ssOe;
   } smsp_pin_out_t;
   typedef struct packed {
      logic [7:0] control;
      logic [4:0] pinDir;
      logic dspeed;
      logic done;
      logic col;
      logic armDone;
      logic armCol;
   } smsp_regs_t;
   typedef struct packed {
      smsp_regs_t regs;
      logic [7:0] txShift;
      logic [7:0] rxShift;
      logic [7:0] rxBuf;
      logic [2:0] slvCnt;
      logic [3:0] edgeIdx;
      logic [6:0] divCnt;
      smsp_mst_t mst;
      logic [1:0] smpPipe;
      logic [1:0] drainCnt;
      logic sckLvl;
      logic sckS1;
      logic sckS2;
      logic sckS3;
      logic ssS1;
      logic ssS2;
      logic mosiS1;
      logic mosiS2;
      logic misoS1;
      logic misoS2;
      logic [7:0] busIdx;
      logic wrPend;
      logic rdPend;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      smsp_pin_out_t pins;
      logic irq;
   } smsp_state_t;
endpackage

/* File: core/spi_master_slave_port.sv */
`timescale 1ns/1ns
// Functional notes
// - Selected slave drives MISO only when its direction bit says output.
// - Deselected slave is passive, ignores data, clears its bit counter.
// - Slave select rising discards partial byte, clears bit count and receive shift; transmit shift keeps its value.
// - Master with slave select as output: pin is plain output.
// - Master with slave select input low: drop to slave, pins input.
// - That drop to slave sets the transfer-complete flag.
// - Data launched on one SCK edge, captured on the opposite edge.
// - Polarity one idles SCK high; zero idles it low.
// - Phase zero samples leading edge; phase one samples trailing edge.
// - bit_order one sends LSB first, zero sends MSB first.
// - Nothing shifts unless port_enable is one.
// - Interrupt request when enable, done flag and global enable all set.
// - Master divider by double_speed and rate bits: 4..128 or 2..64.
// - Rate bits do nothing in slave role.
// - Done flag set at end of every completed byte.
// - Vector acknowledge clears the done flag.
// - Status read seeing done, then data access, clears done.
// - Data write during transfer sets the collision flag.
// - Status read seeing collision, then data access, clears both flags.
// - Status bits five to one read as zero.
// - Master SCK may reach two core clocks; slave limit quarter rate.
// - Data write starts transfer; data read returns receive buffer.
// - Single transmit buffer, double receive buffer; late read loses byte.
// - Exactly eight bits per transfer; master clock stops afterwards.
module spi_master_slave_port (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire smsp_pkg::smsp_pin_in_t pinIn,
   output smsp_pkg::smsp_pin_out_t pinOut,
   input wire logic globalIrqEn,
   input wire logic vectorAck,
   output logic xferIrq
);
   // =====================================================
   // Helpers
   function automatic logic [7:0] shiftOut(logic [7:0] v, logic lsb);
      return lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
   endfunction

   function automatic logic [7:0] shiftIn(logic [7:0] v, logic b, logic lsb);
      return lsb ? {b, v[7:1]} : {v[6:0], b};
   endfunction

   smsp_pkg::smsp_state_t st_r;
   smsp_pkg::smsp_state_t st_nxt;
   logic en;
   logic isMst;
   logic cpol;
   logic cpha;
   logic lsb;
   logic accept;
   logic dataAcc;
   logic dataWr;
   logic busy;
   logic slvAct;
   logic leadEv;
   logic trailEv;
   logic smpEv;
   logic setEv;
   logic doneSet;
   logic [2:0] rateCode;
   logic [6:0] half;
   logic [7:0] newRx;

   // =====================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      en = st_r.regs.control[smsp_pkg::CTL_EN];
      isMst = st_r.regs.control[smsp_pkg::CTL_MST];
      cpol = st_r.regs.control[smsp_pkg::CTL_CPOL];
      cpha = st_r.regs.control[smsp_pkg::CTL_CPHA];
      lsb = st_r.regs.control[smsp_pkg::CTL_LSB];
      doneSet = 1'b0;
      newRx = 8'h00;
      // Pins are asynchronous to core_clk, so every input passes two stages.
      st_nxt.sckS1 = pinIn.sck;
      st_nxt.sckS2 = st_r.sckS1;
      st_nxt.sckS3 = st_r.sckS2;
      st_nxt.ssS1 = pinIn.ss;
      st_nxt.ssS2 = st_r.ssS1;
      st_nxt.mosiS1 = pinIn.mosi;
      st_nxt.mosiS2 = st_r.mosiS1;
      st_nxt.misoS1 = pinIn.miso;
      st_nxt.misoS2 = st_r.misoS1;

      // Bus: writes take no wait state, reads take one so that a write in
      // the preceding data phase is already visible to the read.
      accept = hsel & hready & htrans[1];
      st_nxt.wrPend = accept & hwrite;
      st_nxt.rdPend = accept & ~hwrite;
      st_nxt.hreadyout = ~(accept & ~hwrite);
      st_nxt.hresp = 1'b0;
      if (accept) begin
         st_nxt.busIdx = haddr[9:2];
      end
      dataAcc = (st_r.wrPend | st_r.rdPend) && (st_r.busIdx == smsp_pkg::IDX_DATA);
      dataWr = st_r.wrPend && (st_r.busIdx == smsp_pkg::IDX_DATA);
      slvAct = en & ~isMst & ~st_r.ssS2;
      busy = (st_r.mst != smsp_pkg::MST_IDLE) | (slvAct & (st_r.slvCnt != 3'h0));

      // Flag clears come first so that any set further down wins.
      if (dataAcc) begin
         if (st_r.regs.armCol) begin
            st_nxt.regs.col = 1'b0;
            st_nxt.regs.done = 1'b0;
         end
         if (st_r.regs.armDone) begin
            st_nxt.regs.done = 1'b0;
         end
         st_nxt.regs.armCol = 1'b0;
         st_nxt.regs.armDone = 1'b0;
      end
      if (vectorAck) begin
         st_nxt.regs.done = 1'b0;
      end

      if (st_r.rdPend) begin
         case (st_r.busIdx)
            smsp_pkg::IDX_CONTROL: st_nxt.hrdata = {24'h000000, st_r.regs.control};
            smsp_pkg::IDX_STATUS: begin
               st_nxt.hrdata = {24'h000000, st_r.regs.done, st_r.regs.col, 5'h00,
                                st_r.regs.dspeed};
               st_nxt.regs.armDone = st_r.regs.done;
               st_nxt.regs.armCol = st_r.regs.col;
            end
            smsp_pkg::IDX_DATA: st_nxt.hrdata = {24'h000000, st_r.rxBuf};
            smsp_pkg::IDX_PINDIR: st_nxt.hrdata = {27'h0000000, st_r.regs.pinDir};
            default: st_nxt.hrdata = 32'h00000000;
         endcase
      end
      if (st_r.wrPend) begin
         case (st_r.busIdx)
            smsp_pkg::IDX_CONTROL: st_nxt.regs.control = hwdata[7:0];
            smsp_pkg::IDX_STATUS: st_nxt.regs.dspeed = hwdata[smsp_pkg::ST_DSPEED];
            smsp_pkg::IDX_PINDIR: st_nxt.regs.pinDir = hwdata[4:0];
            default: st_nxt.regs.dspeed = st_nxt.regs.dspeed;
         endcase
      end

      // =====================================================
      // Master engine; the divider is only consulted here.
      rateCode = {st_r.regs.dspeed, st_r.regs.control[smsp_pkg::CTL_R1],
                  st_r.regs.control[smsp_pkg::CTL_R0]};
      half = smsp_pkg::HALF_TABLE[rateCode];
      st_nxt.smpPipe = {st_r.smpPipe[0], 1'b0};
      case (st_r.mst)
         smsp_pkg::MST_IDLE: begin
            st_nxt.sckLvl = cpol;
         end
         smsp_pkg::MST_RUN: begin
            // A compare with >= survives a rate change in mid byte.
            if (st_r.divCnt >= half - 7'h01) begin
               st_nxt.divCnt = 7'h00;
               st_nxt.sckLvl = ~st_r.sckLvl;
               st_nxt.edgeIdx = st_r.edgeIdx + 4'h1;
               if (st_r.edgeIdx[0] == cpha) begin
                  st_nxt.smpPipe[0] = 1'b1;
               end else if (st_r.edgeIdx != 4'h0 && st_r.edgeIdx != smsp_pkg::LAST_EDGE) begin
                  st_nxt.txShift = shiftOut(st_r.txShift, lsb);
               end
               if (st_r.edgeIdx == smsp_pkg::LAST_EDGE) begin
                  st_nxt.mst = smsp_pkg::MST_DRAIN;
                  st_nxt.drainCnt = smsp_pkg::DRAIN_LEN;
               end
            end else begin
               st_nxt.divCnt = st_r.divCnt + 7'h01;
            end
         end
         smsp_pkg::MST_DRAIN: begin
            // Wait for the last sample to clear the input synchronizer.
            if (st_r.drainCnt == 2'h1) begin
               st_nxt.mst = smsp_pkg::MST_IDLE;
               st_nxt.rxBuf = st_r.rxShift;
               doneSet = 1'b1;
            end else begin
               st_nxt.drainCnt = st_r.drainCnt - 2'h1;
            end
         end
         default: st_nxt.mst = smsp_pkg::MST_IDLE;
      endcase
      // Sampling lags the SCK edge by the synchronizer depth, so MISO is
      // seen as it stood in the last clock before the edge.
      if (st_r.smpPipe[1]) begin
         st_nxt.rxShift = shiftIn(st_r.rxShift, st_r.misoS2, lsb);
      end
      if (st_r.mst != smsp_pkg::MST_IDLE && (!en || !isMst)) begin
         st_nxt.mst = smsp_pkg::MST_IDLE;
      end

      // =====================================================
      // Slave engine. Edges are found on synchronized samples, so each SCK
      // phase must outlast two core clocks.
      leadEv = cpol ? (~st_r.sckS2 & st_r.sckS3) : (st_r.sckS2 & ~st_r.sckS3);
      trailEv = cpol ? (st_r.sckS2 & ~st_r.sckS3) : (~st_r.sckS2 & st_r.sckS3);
      smpEv = slvAct & (cpha ? trailEv : leadEv);
      setEv = slvAct & (cpha ? leadEv : trailEv);
      if (!slvAct) begin
         st_nxt.slvCnt = 3'h0;
         if (!isMst) begin
            st_nxt.rxShift = 8'h00;
         end
      end else if (smpEv) begin
         newRx = shiftIn(st_r.rxShift, st_r.mosiS2, lsb);
         st_nxt.rxShift = newRx;
         st_nxt.slvCnt = st_r.slvCnt + 3'h1;
         if (st_r.slvCnt == smsp_pkg::LAST_BIT) begin
            st_nxt.rxBuf = newRx;
            doneSet = 1'b1;
         end
      end else if (setEv && st_r.slvCnt != 3'h0) begin
         st_nxt.txShift = shiftOut(st_r.txShift, lsb);
      end

      // =====================================================
      // Data write: load and start, or flag a collision.
      if (dataWr) begin
         if (busy) begin
            st_nxt.regs.col = 1'b1;
         end else begin
            st_nxt.txShift = hwdata[7:0];
            if (en && isMst) begin
               st_nxt.mst = smsp_pkg::MST_RUN;
               st_nxt.divCnt = 7'h00;
               st_nxt.edgeIdx = 4'h0;
               st_nxt.sckLvl = cpol;
               st_nxt.rxShift = 8'h00;
            end
         end
      end

      // Mode fault: another master has selected us.
      if (en && isMst && !st_r.regs.pinDir[smsp_pkg::DIR_SS] && !st_r.ssS2) begin
         st_nxt.regs.control[smsp_pkg::CTL_MST] = 1'b0;
         st_nxt.mst = smsp_pkg::MST_IDLE;
         doneSet = 1'b1;
      end
      if (doneSet) begin
         st_nxt.regs.done = 1'b1;
      end

      // =====================================================
      // Pin drivers, registered from the next state.
      st_nxt.pins.sckOut = st_nxt.sckLvl;
      st_nxt.pins.mosiOut = lsb ? st_nxt.txShift[0] : st_nxt.txShift[7];
      st_nxt.pins.misoOut = st_nxt.pins.mosiOut;
      st_nxt.pins.sckOe = st_nxt.regs.control[smsp_pkg::CTL_EN]
                          & st_nxt.regs.control[smsp_pkg::CTL_MST]
                          & st_nxt.regs.pinDir[smsp_pkg::DIR_SCK];
      st_nxt.pins.mosiOe = st_nxt.regs.control[smsp_pkg::CTL_EN]
                           & st_nxt.regs.control[smsp_pkg::CTL_MST]
                           & st_nxt.regs.pinDir[smsp_pkg::DIR_MOSI];
      // Select is taken from the second synchronizer stage only, so the MISO
      // enable trails the pin by one more clock than the slave logic does.
      st_nxt.pins.misoOe = st_nxt.regs.control[smsp_pkg::CTL_EN]
                           & ~st_nxt.regs.control[smsp_pkg::CTL_MST]
                           & ~st_r.ssS2
                           & st_nxt.regs.pinDir[smsp_pkg::DIR_MISO];
      st_nxt.pins.ssOut = st_nxt.regs.pinDir[smsp_pkg::DIR_SSVAL];
      st_nxt.pins.ssOe = st_nxt.regs.pinDir[smsp_pkg::DIR_SS];
      st_nxt.irq = st_nxt.regs.control[smsp_pkg::CTL_IE] & st_nxt.regs.done
                   & globalIrqEn;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st_r <= '0;
         st_r.hreadyout <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hreadyout = st_r.hreadyout;
   assign hresp = st_r.hresp;
   assign hrdata = st_r.hrdata;
   assign pinOut = st_r.pins;
   assign xferIrq = st_r.irq;

   // =====================================================
   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_last_edge;
      (st_r.mst == smsp_pkg::MST_RUN) ##1 (st_r.mst == smsp_pkg::MST_DRAIN);
   endsequence

   sequence s_drain_done;
      (st_r.mst == smsp_pkg::MST_DRAIN) [*3] ##1
         (st_r.mst == smsp_pkg::MST_IDLE && st_r.regs.done);
   endsequence

   chk_deselect_reset: assert property (!isMst && st_r.ssS2 |=>
      st_r.slvCnt == 3'h0 && st_r.rxShift == 8'h00)
      else $error("slave logic not reset while deselected");
   chk_miso_drive: assert property (pinOut.misoOe |->
      !isMst && !$past(st_r.ssS2) && st_r.regs.pinDir[smsp_pkg::DIR_MISO])
      else $error("MISO driven while not a selected slave");
   chk_mode_fault: assert property (en && isMst && !st_r.ssS2 &&
      !st_r.regs.pinDir[smsp_pkg::DIR_SS] |=> !isMst && st_r.regs.done && !pinOut.sckOe)
      else $error("mode fault did not drop master role");
   chk_sck_idle: assert property (st_r.mst == smsp_pkg::MST_IDLE |=>
      pinOut.sckOut == $past(cpol))
      else $error("SCK not at idle level");
   chk_byte_end: assert property (disable iff (!rst_b || !en || !isMst)
      s_last_edge |-> s_drain_done)
      else $error("master byte did not finish on time");
   chk_rate_fast: assert property (st_r.mst == smsp_pkg::MST_RUN &&
      half == 7'h02 && st_r.divCnt == 7'h00 && en && isMst && !st_r.wrPend &&
      (st_r.ssS2 || st_r.regs.pinDir[smsp_pkg::DIR_SS]) |=>
      $stable(pinOut.sckOut) ##1 $changed(pinOut.sckOut))
      else $error("SCK half period wrong for divide by four");
   chk_collision: assert property (dataWr && busy |=> st_r.regs.col)
      else $error("collision flag not set");
   chk_col_clear: assert property (dataAcc && st_r.regs.armCol && !busy |=>
      !st_r.regs.col)
      else $error("collision flag not cleared");
   chk_done_clear: assert property (dataAcc && st_r.regs.armDone && !doneSet |=>
      !st_r.regs.done)
      else $error("done flag not cleared");
   chk_irq_req: assert property (st_r.regs.done && st_r.regs.control[smsp_pkg::CTL_IE] &&
      globalIrqEn && !vectorAck && !dataAcc && !st_r.wrPend |=> xferIrq)
      else $error("interrupt request missing");
   chk_disabled_idle: assert property (!en |=> st_r.mst == smsp_pkg::MST_IDLE &&
      st_r.slvCnt == 3'h0)
      else $error("activity while port disabled");

   // =====================================================
   // Pin drivers, flag delivery and register bus timing. A set of the done
   // flag always wins over a clear in the same cycle, so clears are checked
   // only where no set can coincide.
   chk_sck_drive: assert property ((pinOut.sckOe || pinOut.mosiOe) |->
      en && isMst)
      else $error("SCK or MOSI driven outside master role");
   chk_ss_output: assert property (en && isMst && !st_r.wrPend &&
      st_r.regs.pinDir[smsp_pkg::DIR_SS] |=> isMst)
      else $error("master role lost with select pin as output");
   chk_master_done: assert property (st_r.mst == smsp_pkg::MST_DRAIN &&
      st_r.drainCnt == 2'h1 && en && isMst |=>
      st_r.regs.done && st_r.rxBuf == $past(st_r.rxShift))
      else $error("master byte not delivered to receive buffer");
   chk_slave_byte: assert property (smpEv && st_r.slvCnt == smsp_pkg::LAST_BIT
      |=> st_r.regs.done && st_r.slvCnt == 3'h0)
      else $error("slave byte end not flagged");
   chk_status_zero: assert property (st_r.rdPend &&
      st_r.busIdx == smsp_pkg::IDX_STATUS |=> hrdata[5:1] == 5'h00)
      else $error("reserved status bits not zero");
   chk_vector_clear: assert property (vectorAck && !doneSet |=> !st_r.regs.done)
      else $error("done flag not cleared by vector");
   chk_irq_masked: assert property (!globalIrqEn |=> !xferIrq)
      else $error("interrupt request while globally masked");
   chk_read_wait: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   chk_tx_start: assert property (dataWr && !busy && en && isMst &&
      (st_r.ssS2 || st_r.regs.pinDir[smsp_pkg::DIR_SS]) |=> st_r.mst == smsp_pkg::MST_RUN)
      else $error("data write did not start a transfer");
   chk_sck_stop: assert property (st_r.mst == smsp_pkg::MST_DRAIN |=>
      $stable(pinOut.sckOut))
      else $error("SCK moved after the last edge");
endmodule

/* File: tb/smsp_partner.sv */
`timescale 1ns/1ns
// =====================================================
// Far-side slave device that shifts one byte each frame.
module smsp_partner (
   input wire logic sck,
   input wire logic ss_b,
   input wire logic mosi,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic lsbFirst,
   input wire logic [7:0] txByte,
   output logic miso,
   output logic [7:0] rxByte
);
   int k;
   function automatic int pos(input int i);
      return lsbFirst ? i : 7 - i;
   endfunction
   initial begin
      miso = 1'b0;
      rxByte = 8'h00;
      k = 0;
   end
   // A released line shows the inverse of its last level, so a stale bit never matches.
   always @(posedge ss_b) miso = ~miso;
   always @(negedge ss_b) begin
      k = 0;
      if (!cpha) miso = txByte[pos(0)];
   end
   always @(sck) begin
      if (!ss_b && k < 8) begin
         if (sck == (cpol == cpha)) begin
            rxByte[pos(k)] = mosi;
            k = k + 1;
         end else begin
            miso = txByte[pos(k)];
         end
      end
   end
endmodule

/* File: tb/spi_master_slave_port_bench.sv */
`timescale 1ns/1ns
module spi_master_slave_port_bench;
   localparam int SCK_DIV [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, xferIrq;
   logic [31:0] hrdata;
   logic globalIrqEn = 1'b1;
   logic vectorAck = 1'b0;
   logic bSck = 1'b0;
   logic bMosi = 1'b0;
   logic bSs_b = 1'b1;
   logic pCpol = 1'b0;
   logic pCpha = 1'b0;
   logic pLsb = 1'b0;
   logic [7:0] pTx = 8'h00;
   logic pMiso;
   logic [7:0] pRx, ctl, mb, sb, x;
   logic s;
   int t;
   int error_cnt = 0;
   int n_checks = 0;
   smsp_pkg::smsp_pin_in_t pinIn;
   smsp_pkg::smsp_pin_out_t pinOut;
   always #4 core_clk = ~core_clk;
   assign pinIn = {pinOut.sckOe ? pinOut.sckOut : bSck, pinOut.mosiOe ? pinOut.mosiOut : bMosi,
                   pinOut.misoOe ? pinOut.misoOut : pMiso, pinOut.ssOe ? pinOut.ssOut : bSs_b};
   spi_master_slave_port dut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pinIn(pinIn), .pinOut(pinOut),
      .globalIrqEn(globalIrqEn), .vectorAck(vectorAck), .xferIrq(xferIrq));
   smsp_partner partner (.sck(pinIn.sck), .ss_b(pinIn.ss), .mosi(pinIn.mosi), .cpol(pCpol),
      .cpha(pCpha), .lsbFirst(pLsb), .txByte(pTx), .miso(pMiso), .rxByte(pRx));
   // =====================================================
   // Bus and comparison tasks.
   task automatic conclude;
      if (error_cnt == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= w;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      rd = hrdata[7:0];
      chk("hresp", {7'h0, hresp}, 8'h00);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] y;
      bus(1'b1, idx, d, y);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
      logic [7:0] y;
      bus(1'b0, idx, 8'h00, y);
      chk(nm, y, e);
   endtask
   task automatic waitDone;
      logic [7:0] y;
      y = 8'h00;
      for (int i = 0; i < 800 && y[7] !== 1'b1; i++) bus(1'b0, smsp_pkg::IDX_STATUS, 8'h00, y);
      chk("done", {7'h0, y[7]}, 8'h01);
   endtask
   task automatic mxfer(input logic [7:0] c, input logic [7:0] m, input logic [7:0] p);
      wr(smsp_pkg::IDX_PINDIR, 8'h1d);
      pCpol <= c[3];
      pCpha <= c[2];
      pLsb <= c[5];
      pTx <= p;
      wr(smsp_pkg::IDX_CONTROL, c);
      wr(smsp_pkg::IDX_PINDIR, 8'h0d);
      wr(smsp_pkg::IDX_DATA, m);
   endtask
   // Acts as an outside master in mode 0; each clock phase lasts four core clocks.
   task automatic sbyte(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         bMosi <= tx[7 - i];
         repeat (4) @(posedge core_clk);
         bSck <= 1'b1;
         rx[7 - i] = pinIn.miso;
         repeat (4) @(posedge core_clk);
         bSck <= 1'b0;
      end
   endtask
   // =====================================================
   // Scenarios.
   initial begin
      repeat (50000) @(posedge core_clk);
      error_cnt++;
      conclude;
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      rdchk("control", smsp_pkg::IDX_CONTROL, 8'h00);
      rdchk("status", smsp_pkg::IDX_STATUS, 8'h00);
      rdchk("pin dir", smsp_pkg::IDX_PINDIR, 8'h00);
      rdchk("unmapped", 8'h10, 8'h00);
      wr(smsp_pkg::IDX_STATUS, 8'hff);
      rdchk("status bits", smsp_pkg::IDX_STATUS, 8'h01);
      wr(smsp_pkg::IDX_STATUS, 8'h00);
      wr(smsp_pkg::IDX_CONTROL, 8'h10);
      wr(smsp_pkg::IDX_DATA, 8'h5a);
      repeat (100) @(posedge core_clk);
      rdchk("disabled", smsp_pkg::IDX_STATUS, 8'h00);
      chk("disabled sck oe", {7'h0, pinOut.sckOe}, 8'h00);
      for (int m = 0; m < 8; m++) begin
         ctl = {1'b0, 1'b1, m[2], 1'b1, m[1], m[0], 2'h0};
         mb = 8'ha1 ^ {m[2:0], 5'h00};
         sb = ~mb ^ 8'h0c;
         mxfer(ctl, mb, sb);
         waitDone;
         chk("mode rx", pRx, mb);
         rdchk("mode data", smsp_pkg::IDX_DATA, sb);
         rdchk("done clear", smsp_pkg::IDX_STATUS, 8'h00);
         chk("sck idle", {7'h0, pinOut.sckOut}, {7'h0, ctl[3]});
      end
      for (int r = 0; r < 8; r++) begin
         wr(smsp_pkg::IDX_STATUS, {7'h0, r[2]});
         mxfer({6'h14, r[1:0]}, 8'h0f, 8'hf0);
         for (int h = 0; h < 2; h++) begin
            s = pinOut.sckOut;
            t = 0;
            while (pinOut.sckOut === s && t < 300) begin
               @(posedge core_clk);
               t++;
            end
         end
         chk("half period", 8'(t), 8'(SCK_DIV[r] / 2));
         waitDone;
         rdchk("rate data", smsp_pkg::IDX_DATA, 8'hf0);
      end
      wr(smsp_pkg::IDX_STATUS, 8'h00);
      mxfer(8'hd0, 8'h3c, 8'h81);
      wr(smsp_pkg::IDX_DATA, 8'hff);
      waitDone;
      chk("irq", {7'h0, xferIrq}, 8'h01);
      rdchk("collision", smsp_pkg::IDX_STATUS, 8'hc0);
      rdchk("col data", smsp_pkg::IDX_DATA, 8'h81);
      rdchk("col clear", smsp_pkg::IDX_STATUS, 8'h00);
      chk("col rx", pRx, 8'h3c);
      globalIrqEn <= 1'b0;
      mxfer(8'hd0, 8'h55, 8'h66);
      waitDone;
      chk("irq masked", {7'h0, xferIrq}, 8'h00);
      vectorAck <= 1'b1;
      @(posedge core_clk);
      vectorAck <= 1'b0;
      repeat (2) @(posedge core_clk);
      rdchk("vector clear", smsp_pkg::IDX_STATUS, 8'h00);
      // Raise the select pin before handing it back to the input side, or the
      // synchronizer still holds the low level and a false mode fault follows.
      wr(smsp_pkg::IDX_PINDIR, 8'h1d);
      wr(smsp_pkg::IDX_PINDIR, 8'h05);
      wr(smsp_pkg::IDX_CONTROL, 8'h50);
      rdchk("pre fault", smsp_pkg::IDX_STATUS, 8'h00);
      bSs_b <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk("fault oe", {6'h0, pinOut.sckOe, pinOut.mosiOe}, 8'h00);
      rdchk("fault mst", smsp_pkg::IDX_CONTROL, 8'h40);
      rdchk("fault done", smsp_pkg::IDX_STATUS, 8'h80);
      rdchk("fault data", smsp_pkg::IDX_DATA, 8'h66);
      bSs_b <= 1'b1;
      wr(smsp_pkg::IDX_CONTROL, 8'h50);
      rdchk("mst again", smsp_pkg::IDX_CONTROL, 8'h50);
      wr(smsp_pkg::IDX_CONTROL, 8'h43);
      wr(smsp_pkg::IDX_PINDIR, 8'h02);
      wr(smsp_pkg::IDX_DATA, 8'h3c);
      bSs_b <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk("slave oe", {5'h0, pinOut.sckOe, pinOut.mosiOe, pinOut.misoOe}, 8'h01);
      sbyte(8'hc5, 3, x);
      bSs_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk("passive oe", {7'h0, pinOut.misoOe}, 8'h00);
      rdchk("partial", smsp_pkg::IDX_STATUS, 8'h00);
      wr(smsp_pkg::IDX_DATA, 8'h3c);
      bSs_b <= 1'b0;
      repeat (4) @(posedge core_clk);
      sbyte(8'ha5, 8, x);
      repeat (8) @(posedge core_clk);
      chk("slave miso", x, 8'h3c);
      rdchk("slave done", smsp_pkg::IDX_STATUS, 8'h80);
      rdchk("slave data", smsp_pkg::IDX_DATA, 8'ha5);
      bSs_b <= 1'b1;
      conclude;
   end
endmodule
